// file: include/mrs_pkg.sv
package mrs_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    MRS_CMD_NONE      = 4'h0,
    MRS_CMD_TST_Q     = 4'h1,
    MRS_CMD_WAIT      = 4'h2,
    MRS_CMD_RESET     = 4'h3,
    MRS_CMD_CRANGE    = 4'h4,
    MRS_CMD_CRANGE_Q  = 4'h5,
    MRS_CMD_CAUTO     = 4'h6,
    MRS_CMD_CAUTO_Q   = 4'h7,
    MRS_CMD_CSCAL     = 4'h8,
    MRS_CMD_CSCAL_Q   = 4'h9,
    MRS_CMD_CTR       = 4'ha,
    MRS_CMD_CTR_Q     = 4'hb,
    MRS_CMD_VRANGE    = 4'hc,
    MRS_CMD_VRANGE_Q  = 4'hd,
    MRS_CMD_VAUTO     = 4'he,
    MRS_CMD_VAUTO_Q   = 4'hf
  } mrs_cmd_t;

  // Response number format
  typedef enum logic [1:0] {
    MRS_FMT_NR1 = 2'h1,
    MRS_FMT_NR3 = 2'h2
  } mrs_fmt_t;

  // ----------------------------------------
  // Current range codes, ascending 5 mA .. 20 A
  // ----------------------------------------
  localparam logic [3:0] MRS_CRANGE_MAX_CODE = 4'hb;
  localparam logic [3:0] MRS_CRANGE_DEFAULT = 4'hb;

  // Voltage range codes
  localparam logic [15:0] MRS_VRANGE_LOW = 16'h0096;
  localparam logic [15:0] MRS_VRANGE_HIGH = 16'h012c;
  localparam logic [15:0] MRS_VRANGE_DEFAULT = 16'h012c;

  // CT ratio limits and defaults
  localparam logic [15:0] MRS_CTR_MIN = 16'h0001;
  localparam logic [15:0] MRS_CTR_MAX = 16'h07d0;
  localparam logic [15:0] MRS_CTR_DEFAULT = 16'h0001;
  localparam logic MRS_CAUTO_DEFAULT = 1'h1;
  localparam logic MRS_VAUTO_DEFAULT = 1'h1;
  localparam logic MRS_CSCAL_DEFAULT = 1'h0;
  localparam logic [15:0] MRS_TST_RESULT = 16'h0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    mrs_cmd_t code;
    logic [15:0] arg;
  } mrs_req_t;

  typedef struct packed {
    mrs_fmt_t fmt;
    logic [15:0] value;
  } mrs_rsp_t;

  typedef struct packed {
    logic [3:0] current_range_select;
    logic current_autorange_switch;
    logic current_scaling_switch;
    logic [15:0] current_transformer_ratio;
    logic [15:0] voltage_range_select;
    logic voltage_autorange_switch;
  } mrs_settings_t;

endpackage

// file: design/mrs_range_check.sv
`timescale 1ns/1ps
module mrs_range_check
  import mrs_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] lo,
  input wire logic [WIDTH-1:0] hi,
  output logic inside_range
);
  // Stop at elaboration rather than build a zero-width comparator
  if (WIDTH < 1)
  begin : g_width_bad
    $error("Width must be positive");
  end

  assign inside_range = (value >= lo) && (value <= hi);
endmodule // mrs_range_check

// file: design/mrs_settings.sv
`timescale 1ns/1ps
// Overview of operation
// - Self-test query always answers zero
// - Wait holds later commands until idle
// - Current range: twelve values, default 20 A
// - Writing current range clears current autorange
// - Current autorange takes on/off, default on
// - Current scaling takes on/off, default off
// - CT ratio 1..2000, default 1, scaling-gated
// - Voltage range 150 or 300, default 300
// - Writing voltage range clears voltage autorange
// - Voltage autorange takes on/off, default on
// - Current range query answers NR3
// - Switch queries answer NR1 one or zero
// - CT ratio, voltage range queries answer NR3
// - Reset command aborts measurement, restores defaults
module mrs_settings
  import mrs_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire mrs_pkg::mrs_req_t req,
  input wire logic ops_pending,
  output logic req_ready,
  output logic rsp_valid,
  output mrs_pkg::mrs_rsp_t rsp,
  output logic param_error,
  output logic abort_measure,
  output mrs_pkg::mrs_settings_t settings,
  output logic [15:0] effective_ct_ratio
);
  import mrs_pkg::*;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    MRS_ST_IDLE = 2'b01,
    MRS_ST_WAIT = 2'b10
  } mrs_state_t;

  mrs_state_t state_q;
  mrs_state_t state_d;
  mrs_settings_t set_q;
  mrs_settings_t set_d;
  logic rsp_valid_q;
  logic rsp_valid_d;
  mrs_rsp_t rsp_q;
  mrs_rsp_t rsp_d;
  logic perr_q;
  logic perr_d;
  logic abort_q;
  logic abort_d;
  logic [15:0] eff_q;
  logic [15:0] eff_d;
  logic ready_q;
  logic ready_d;
  logic take;
  logic ctr_ok;
  logic crange_ok;

  mrs_range_check #(
    .WIDTH(16)
  ) u_ctr_check (
    .value(req.arg),
    .lo(MRS_CTR_MIN),
    .hi(MRS_CTR_MAX),
    .inside_range(ctr_ok)
  );

  // Range codes are dense 0..11, so the same comparator serves
  mrs_range_check #(
    .WIDTH(16)
  ) u_crange_check (
    .value(req.arg),
    .lo(16'h0000),
    .hi({12'h000, MRS_CRANGE_MAX_CODE}),
    .inside_range(crange_ok)
  );

  assign take = req_valid && ready_q;

  always_comb
  begin
    state_d = state_q;
    set_d = set_q;
    rsp_valid_d = 1'b0;
    rsp_d = rsp_q;
    perr_d = 1'b0;
    abort_d = 1'b0;
    ready_d = ready_q;
    unique case (state_q)
      MRS_ST_IDLE:
      begin
        if (take)
        begin
          unique case (req.code)
            MRS_CMD_TST_Q:
            begin
              rsp_valid_d = 1'b1;
              rsp_d = '{fmt: MRS_FMT_NR1, value: MRS_TST_RESULT};
            end
            MRS_CMD_WAIT:
            begin
              if (ops_pending)
              begin
                state_d = MRS_ST_WAIT;
                ready_d = 1'b0;
              end
            end
            MRS_CMD_RESET:
            begin
              abort_d = 1'b1;
              set_d = '{MRS_CRANGE_DEFAULT, MRS_CAUTO_DEFAULT, MRS_CSCAL_DEFAULT,
                        MRS_CTR_DEFAULT, MRS_VRANGE_DEFAULT, MRS_VAUTO_DEFAULT};
            end
            MRS_CMD_CRANGE:
            begin
              if (crange_ok)
              begin
                set_d.current_range_select = req.arg[3:0];
                set_d.current_autorange_switch = 1'b0;
              end
              else
              begin
                perr_d = 1'b1;
              end
            end
            MRS_CMD_CRANGE_Q:
            begin
              rsp_valid_d = 1'b1;
              rsp_d = '{fmt: MRS_FMT_NR3, value: {12'h000, set_q.current_range_select}};
            end
            MRS_CMD_CAUTO:
            begin
              if (req.arg[15:1] == 15'h0000)
                set_d.current_autorange_switch = req.arg[0];
              else
                perr_d = 1'b1;
            end
            MRS_CMD_CAUTO_Q:
            begin
              rsp_valid_d = 1'b1;
              rsp_d = '{fmt: MRS_FMT_NR1, value: {15'h0000, set_q.current_autorange_switch}};
            end
            MRS_CMD_CSCAL:
            begin
              if (req.arg[15:1] == 15'h0000)
                set_d.current_scaling_switch = req.arg[0];
              else
                perr_d = 1'b1;
            end
            MRS_CMD_CSCAL_Q:
            begin
              rsp_valid_d = 1'b1;
              rsp_d = '{fmt: MRS_FMT_NR1, value: {15'h0000, set_q.current_scaling_switch}};
            end
            MRS_CMD_CTR:
            begin
              if (ctr_ok)
                set_d.current_transformer_ratio = req.arg;
              else
                perr_d = 1'b1;
            end
            MRS_CMD_CTR_Q:
            begin
              rsp_valid_d = 1'b1;
              rsp_d = '{fmt: MRS_FMT_NR3, value: set_q.current_transformer_ratio};
            end
            MRS_CMD_VRANGE:
            begin
              if (req.arg == MRS_VRANGE_LOW || req.arg == MRS_VRANGE_HIGH)
              begin
                set_d.voltage_range_select = req.arg;
                set_d.voltage_autorange_switch = 1'b0;
              end
              else
                perr_d = 1'b1;
            end
            MRS_CMD_VRANGE_Q:
            begin
              rsp_valid_d = 1'b1;
              rsp_d = '{fmt: MRS_FMT_NR3, value: set_q.voltage_range_select};
            end
            MRS_CMD_VAUTO:
            begin
              if (req.arg[15:1] == 15'h0000)
                set_d.voltage_autorange_switch = req.arg[0];
              else
                perr_d = 1'b1;
            end
            MRS_CMD_VAUTO_Q:
            begin
              rsp_valid_d = 1'b1;
              rsp_d = '{fmt: MRS_FMT_NR1, value: {15'h0000, set_q.voltage_autorange_switch}};
            end
            default:
            begin
            end
          endcase
        end
      end
      MRS_ST_WAIT:
      begin
        if (!ops_pending)
        begin
          state_d = MRS_ST_IDLE;
          ready_d = 1'b1;
        end
      end
      default:
      begin
        state_d = MRS_ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
    // ratio only applies while scaling is on
    eff_d = set_d.current_scaling_switch ? set_d.current_transformer_ratio : MRS_CTR_MIN;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= MRS_ST_IDLE;
      set_q <= '{MRS_CRANGE_DEFAULT, MRS_CAUTO_DEFAULT, MRS_CSCAL_DEFAULT,
                 MRS_CTR_DEFAULT, MRS_VRANGE_DEFAULT, MRS_VAUTO_DEFAULT};
      rsp_valid_q <= 1'b0;
      rsp_q <= '{fmt: MRS_FMT_NR1, value: 16'h0000};
      perr_q <= 1'b0;
      abort_q <= 1'b0;
      eff_q <= MRS_CTR_MIN;
      ready_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      set_q <= set_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      perr_q <= perr_d;
      abort_q <= abort_d;
      eff_q <= eff_d;
      ready_q <= ready_d;
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign param_error = perr_q;
  assign abort_measure = abort_q;
  assign settings = set_q;
  assign effective_ct_ratio = eff_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_selftest_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    take && req.code == MRS_CMD_TST_Q |=> rsp_valid && rsp.value == 16'h0000 && rsp.fmt == MRS_FMT_NR1)
    else $error("Self-test answer not zero");
  a_wait_stall: assert property (@(posedge mclk) disable iff (!reset_n)
    take && req.code == MRS_CMD_WAIT && ops_pending |=> !req_ready)
    else $error("Wait did not stall");
  a_wait_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    !req_ready && ops_pending |=> !req_ready)
    else $error("Wait released while busy");
  a_wait_release: assert property (@(posedge mclk) disable iff (!reset_n)
    !req_ready && !ops_pending |=> req_ready)
    else $error("Wait did not release");
  a_crange_bad: assert property (@(posedge mclk) disable iff (!reset_n)
    take && req.code == MRS_CMD_CRANGE && req.arg > 16'h000b
    |=> param_error && $stable(settings.current_range_select))
    else $error("Bad current range accepted");
  a_crange_auto: assert property (@(posedge mclk) disable iff (!reset_n)
    take && req.code == MRS_CMD_CRANGE && req.arg <= 16'h000b
    |=> !settings.current_autorange_switch && settings.current_range_select == $past(req.arg[3:0]))
    else $error("Current autorange not cleared");
  a_vrange_auto: assert property (@(posedge mclk) disable iff (!reset_n)
    take && req.code == MRS_CMD_VRANGE && (req.arg == 16'h0096 || req.arg == 16'h012c)
    |=> !settings.voltage_autorange_switch)
    else $error("Voltage autorange not cleared");
  a_vrange_set: assert property (@(posedge mclk) disable iff (!reset_n)
    settings.voltage_range_select == 16'h0096 || settings.voltage_range_select == 16'h012c)
    else $error("Voltage range illegal");
  a_ctr_bounds: assert property (@(posedge mclk) disable iff (!reset_n)
    settings.current_transformer_ratio >= 16'h0001 && settings.current_transformer_ratio <= 16'h07d0)
    else $error("CT ratio out of bounds");
  a_ctr_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    !settings.current_scaling_switch |-> effective_ct_ratio == 16'h0001)
    else $error("CT ratio applied without scaling");
  a_reset_defaults: assert property (@(posedge mclk) disable iff (!reset_n)
    take && req.code == MRS_CMD_RESET |=> abort_measure && settings.current_range_select == 4'hb
    && settings.current_autorange_switch && !settings.current_scaling_switch
    && settings.current_transformer_ratio == 16'h0001 && effective_ct_ratio == 16'h0001
    && settings.voltage_range_select == 16'h012c && settings.voltage_autorange_switch)
    else $error("Reset did not restore defaults");
  a_ctr_query: assert property (@(posedge mclk) disable iff (!reset_n)
    take && req.code == MRS_CMD_CTR_Q |=> rsp_valid && rsp.fmt == MRS_FMT_NR3
    && rsp.value == $past(settings.current_transformer_ratio))
    else $error("CT ratio query wrong");
endmodule // mrs_settings

// file: bench/mrs_ctrl_model.sv
`timescale 1ns/1ps
module mrs_ctrl_model
(
  input wire logic mclk,
  input wire logic req_ready,
  output logic req_valid,
  output mrs_pkg::mrs_req_t req
);
  import mrs_pkg::*;

  // ----------------------------------------
  // Request driver
  // ----------------------------------------
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end

  // Ready is looked at mid-cycle, so the taking edge never races the design
  task automatic issue(input mrs_cmd_t c, input logic [15:0] a);
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{c, a};
    @(negedge mclk);
    while (req_ready !== 1'b1)
      @(negedge mclk);
    @(posedge mclk);
    req_valid <= 1'b0;
    // Released fields show garbage, never the last request
    req <= mrs_req_t'(~req);
  endtask
endmodule // mrs_ctrl_model

// file: bench/mrs_settings_tb.sv
`timescale 1ns/1ps
module mrs_settings_tb;
  import mrs_pkg::*;

  // ----------------------------------------
  // Signals and expectations
  // ----------------------------------------
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ops_pending = 1'b0;
  logic req_valid, req_ready, rsp_valid, param_error, abort_measure;
  mrs_req_t req;
  mrs_rsp_t rsp;
  mrs_settings_t settings, exp_s;
  logic [15:0] effective_ct_ratio, arg;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int r;
  localparam mrs_settings_t dflt_set = '{4'hb, 1'h1, 1'h0, 16'h0001, 16'h012c, 1'h1};
  localparam mrs_req_t corners [18] = '{'{MRS_CMD_CRANGE, 16'h000c}, '{MRS_CMD_CRANGE, 16'h0000},
    '{MRS_CMD_CAUTO, 16'h0002}, '{MRS_CMD_CAUTO, 16'h0001}, '{MRS_CMD_CRANGE, 16'h000b},
    '{MRS_CMD_CSCAL, 16'h0001}, '{MRS_CMD_CTR, 16'h0000}, '{MRS_CMD_CTR, 16'h07d1}, '{MRS_CMD_CTR, 16'h07d0},
    '{MRS_CMD_VRANGE, 16'h0097}, '{MRS_CMD_VRANGE, 16'h0096}, '{MRS_CMD_VAUTO, 16'h0001},
    '{MRS_CMD_VRANGE, 16'h012c}, '{MRS_CMD_CSCAL, 16'h0000}, '{MRS_CMD_NONE, 16'h0005},
    '{MRS_CMD_CSCAL, 16'h0001}, '{MRS_CMD_RESET, 16'h0000}, '{MRS_CMD_WAIT, 16'h0000}};

  always #20 mclk = ~mclk;

  mrs_settings mrs_settings_inst (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .ops_pending(ops_pending), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .param_error(param_error), .abort_measure(abort_measure), .settings(settings),
    .effective_ct_ratio(effective_ct_ratio));
  mrs_ctrl_model mrs_ctrl_model_inst (.mclk(mclk), .req_ready(req_ready), .req_valid(req_valid), .req(req));

  function automatic logic bad_arg(mrs_cmd_t c, logic [15:0] a);
    case (c)
      MRS_CMD_CRANGE: return a > 16'h000b;
      MRS_CMD_CAUTO, MRS_CMD_CSCAL, MRS_CMD_VAUTO: return a > 16'h0001;
      MRS_CMD_CTR: return a < 16'h0001 || a > 16'h07d0;
      MRS_CMD_VRANGE: return a != 16'h0096 && a != 16'h012c;
      default: return 1'h0;
    endcase
  endfunction

  function automatic mrs_settings_t nxt(mrs_settings_t s, mrs_cmd_t c, logic [15:0] a);
    if (bad_arg(c, a))
      return s;
    case (c)
      MRS_CMD_RESET: s = dflt_set;
      MRS_CMD_CRANGE: s = '{a[3:0], 1'h0, s.current_scaling_switch, s.current_transformer_ratio,
        s.voltage_range_select, s.voltage_autorange_switch};
      MRS_CMD_CAUTO: s.current_autorange_switch = a[0];
      MRS_CMD_CSCAL: s.current_scaling_switch = a[0];
      MRS_CMD_CTR: s.current_transformer_ratio = a;
      MRS_CMD_VRANGE: s = '{s.current_range_select, s.current_autorange_switch, s.current_scaling_switch,
        s.current_transformer_ratio, a, 1'h0};
      MRS_CMD_VAUTO: s.voltage_autorange_switch = a[0];
      default: ;
    endcase
    return s;
  endfunction

  function automatic mrs_rsp_t rsp_of(mrs_settings_t s, mrs_cmd_t c);
    case (c)
      MRS_CMD_CRANGE_Q: return '{MRS_FMT_NR3, {12'h000, s.current_range_select}};
      MRS_CMD_CAUTO_Q: return '{MRS_FMT_NR1, {15'h0000, s.current_autorange_switch}};
      MRS_CMD_CSCAL_Q: return '{MRS_FMT_NR1, {15'h0000, s.current_scaling_switch}};
      MRS_CMD_CTR_Q: return '{MRS_FMT_NR3, s.current_transformer_ratio};
      MRS_CMD_VRANGE_Q: return '{MRS_FMT_NR3, s.voltage_range_select};
      MRS_CMD_VAUTO_Q: return '{MRS_FMT_NR1, {15'h0000, s.voltage_autorange_switch}};
      default: return '{MRS_FMT_NR1, 16'h0000};
    endcase
  endfunction

  // ----------------------------------------
  // Compare tasks and command runner
  // ----------------------------------------
  task automatic chk_b(logic got, logic exp, string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t flag %s", $time, what);
    end
  endtask

  task automatic chk_w(logic [38:0] got, logic [38:0] exp, string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic run(mrs_cmd_t c, logic [15:0] a);
    logic q;
    mrs_rsp_t rx;
    q = c inside {MRS_CMD_TST_Q, MRS_CMD_CRANGE_Q, MRS_CMD_CAUTO_Q, MRS_CMD_CSCAL_Q, MRS_CMD_CTR_Q,
      MRS_CMD_VRANGE_Q, MRS_CMD_VAUTO_Q};
    rx = rsp_of(exp_s, c);
    chk_b(param_error, 1'h0, "idle error");
    mrs_ctrl_model_inst.issue(c, a);
    // Issue returns on the taking edge; the answer pulses stand until the next edge
    #1;
    chk_b(param_error, bad_arg(c, a), "error");
    exp_s = nxt(exp_s, c, a);
    chk_w(settings, exp_s, "settings");
    chk_b(rsp_valid, q, "answer");
    chk_b(abort_measure, c == MRS_CMD_RESET, "abort");
    chk_w({23'h0, effective_ct_ratio}, {23'h0, exp_s.current_scaling_switch ?
      exp_s.current_transformer_ratio : 16'h0001}, "ratio");
    if (c == MRS_CMD_TST_Q)
      chk_w({23'h0, rsp.value}, 39'h0, "self test");
    else if (q)
      chk_w({21'h0, rsp}, {21'h0, rx}, "reply");
    @(posedge mclk);
    #1;
    chk_b(rsp_valid | param_error | abort_measure, 1'h0, "pulse width");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run needs about 1000 cycles
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  initial
  begin
    r = $urandom(32'h0cf2bf35);
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    exp_s = dflt_set;
    #1;
    chk_w(settings, dflt_set, "reset values");
    for (int c = 1; c < 16; c += 2)
      run(mrs_cmd_t'(c), 16'h0000);
    $display("test defaults done");
    foreach (corners[i])
      run(corners[i].code, corners[i].arg);
    $display("test corners done");
    @(posedge mclk);
    ops_pending <= 1'b1;
    mrs_ctrl_model_inst.issue(MRS_CMD_WAIT, 16'h0000);
    @(posedge mclk);
    #1;
    chk_b(req_ready, 1'h0, "stall");
    fork
      begin
        repeat (4) @(posedge mclk);
        ops_pending <= 1'b0;
      end
    join_none
    run(MRS_CMD_VRANGE_Q, 16'h0000);
    // A query answered before the drop would still see pending high
    chk_b(ops_pending, 1'h0, "held until idle");
    $display("test wait done");
    for (int i = 0; i < 300; i++)
    begin
      r = $urandom;
      arg = r[5:4] == 2'h0 ? 16'($urandom_range(0, 12)) : r[5:4] == 2'h1 ? (r[6] ? 16'h0096 : 16'h012c)
        : 16'($urandom_range(0, 2001));
      run(mrs_cmd_t'(r[3:0]), arg);
    end
    $display("test random done");
    close_out();
  end
endmodule // mrs_settings_tb
